//--- inc/pmcr_consts.vh
// Constants for the partition and monitor configuration register bank
// Overview of operation
// RULE1 - With reset-on-capture set, a capture clears the monitor count.
// RULE2 - Reset-on-capture reads zero and ignores writes when capture or reset is absent.
// RULE3 - Capture-event field bits 30:28 picks the trigger; codes 0-6 are external events.
// RULE4 - Code 7 captures whenever software writes the software capture-trigger register.
// RULE5 - An unimplemented capture-event source never causes a capture.
// RULE6 - Without capture support the capture-event field reads zero, ignores writes.
// RULE7 - Enable bit 31 low stops all collection; high collects per configuration. Captures and clear-on-capture still act while bit 31 is low.
// RULE8 - The system drives external capture events, possibly to many components.
// RULE9 - Main feature ID register sits at offset 0x0000 of the feature page.
// RULE10 - Per-class feature ID register exists only when its presence bit is set.
// RULE11 - Main ID shows monitor presence; monitor ID lists supported monitor types.
// RULE12 - Per-monitor-type ID register exists only when its monitor ID bit is set.
// RULE13 - Each implemented register decodes at its own fixed page offset.
// RULE14 - Software locks, selects partition, writes controls, then unlocks.
// RULE15 - Configuration writes go to the partition held in the select register.
// RULE16 - Configuration reads return the selected partition's settings.
// RULE17 - Separate secure and non-secure select registers, chosen by access security.
// RULE18 - All partition configuration registers are readable and writable.
// RULE19 - An error status register and a separate interrupt control register exist.
// RULE20 - Overflow-freeze bit 24: clear wraps the count, set stops it at overflow.
// RULE21 - A capture copies the count into the capture register before any clearing.
`ifndef PMCR_CONSTS_VH
`define PMCR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register offsets within the feature page
// ----------------------------------------------------------------------------
`define PMCR_OFF_IDR_LO      16'h0000
`define PMCR_OFF_IDR_HI      16'h0004
`define PMCR_OFF_MON_IDR     16'h0080
`define PMCR_OFF_CPOR_IDR    16'h0030
`define PMCR_OFF_CSUMON_IDR  16'h0088
`define PMCR_OFF_ECR         16'h00F0
`define PMCR_OFF_ESR         16'h00F8
`define PMCR_OFF_PART_SEL    16'h0100
`define PMCR_OFF_CPBM        16'h1000
`define PMCR_OFF_MON_CTL     16'h0818
`define PMCR_OFF_MON_CNT     16'h0840
`define PMCR_OFF_MON_CAPT    16'h0844
`define PMCR_OFF_SW_CAPT     16'h0808

// ----------------------------------------------------------------------------
// Monitor control fields
// ----------------------------------------------------------------------------
`define PMCR_CTL_EN          31
`define PMCR_CTL_EVT_HI      30
`define PMCR_CTL_EVT_LO      28
`define PMCR_CTL_RST_CAPT    27
`define PMCR_CTL_OVERFLOW_FREEZE   24
`define PMCR_CTL_OFLOW_STAT  26
`define PMCR_CTL_WMASK       32'hF9000000
`define PMCR_EVT_SW          3'h7

// ----------------------------------------------------------------------------
// Sizes, ID values, error codes
// ----------------------------------------------------------------------------
`define PMCR_PID_W           4
`define PMCR_NPART           16
`define PMCR_PID_MAX         16'h000F
`define PMCR_PMG_MAX         8'h03
`define PMCR_CPBM_W          16
`define PMCR_IDR_HAS_CPOR    24
`define PMCR_IDR_HAS_MSMON   30
`define PMCR_MON_HAS_CSU     16
`define PMCR_CSU_HAS_CAPT    31
`define PMCR_ERR_PID_RANGE   4'h1
`define PMCR_ERR_UNMAPPED    4'h2
`define PMCR_ERRCODE_LSB     24
`define PMCR_CNT_MAX         32'hFFFFFFFF

`endif

//--- logic/pmcr_part_mem.v
// Small per-partition storage, two banks, registered read data
module pmcr_part_mem (
   input  wire                    clock_i,
   input  wire                    we_i,
   input  wire [4:0]              waddr_i,
   input  wire [15:0]             wdata_i,
   input  wire [4:0]              raddr_i,
   output reg  [15:0]             rdata_o
);
   reg [15:0] mem_q [0:31];

   always @(posedge clock_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule // pmcr_part_mem

//--- logic/pmcr_monitor.v
// One counting monitor with capture, reset-on-capture and overflow freeze
`include "pmcr_consts.vh"
module pmcr_monitor (
   input  wire        clock_i,
   input  wire        srst_i,
   input  wire        enable_i,
   input  wire        count_event_i,
   input  wire        capture_i,
   input  wire        reset_on_capture_i,
   input  wire        overflow_freeze_i,
   input  wire        cnt_we_i,
   input  wire [31:0] cnt_wdata_i,
   input  wire        stat_clr_i,
   output reg  [31:0] count_o,
   output reg  [31:0] capture_o,
   output reg         overflow_o
);
   wire at_max = (count_o == `PMCR_CNT_MAX);

   always @(posedge clock_i) begin
      if (srst_i) begin
         count_o    <= 32'h00000000;
         capture_o  <= 32'h00000000;
         overflow_o <= 1'b0;
      end else begin
         // RULE21 copy before clear
         if (capture_i) begin
            capture_o <= count_o;
         end
         if (cnt_we_i) begin
            count_o <= cnt_wdata_i;
         // RULE1 clear on capture
         end else if (capture_i && reset_on_capture_i) begin
            count_o <= 32'h00000000;
         // RULE7 gate collection
         end else if (enable_i && count_event_i) begin
            // RULE20 wrap or freeze
            if (!(at_max && overflow_freeze_i)) begin
               count_o <= count_o + 32'h00000001;
            end
         end
         // Overflow set wins over software clear
         if (enable_i && count_event_i && at_max && !cnt_we_i) begin
            overflow_o <= 1'b1;
         end else if (stat_clr_i) begin
            overflow_o <= 1'b0;
         end
      end
   end
endmodule // pmcr_monitor

//--- logic/pmcr_regs.v
// Partition and monitor configuration register bank, top level
`include "pmcr_consts.vh"
module pmcr_regs #(
   parameter       HAS_CAPTURE   = 1,
   parameter       MON_RESETABLE = 1,
   parameter [6:0] EXT_EVT_IMPL  = 7'h01
) (
   input  wire        clock_i,
   input  wire        srst_i,
   input  wire        req_i,
   input  wire        wr_i,
   input  wire        ns_i,
   input  wire [15:0] addr_i,
   input  wire [31:0] wdata_i,
   input  wire [6:0]  ext_capture_i,
   input  wire        count_event_i,
   output reg  [31:0] rdata_o,
   output reg         ack_o,
   output reg  [15:0] cpbm_o,
   output reg         mon_count_en_o
);
   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   localparam ST_IDLE = 2'b01;
   localparam ST_READ = 2'b10;

   reg [1:0]            state_q;
   reg [15:0]           sel_s_q;
   reg [15:0]           sel_ns_q;
   reg [31:0]           ctl_q;
   reg                  sw_capt_q;
   reg [31:0]           ecr_q;
   reg [31:0]           esr_q;
   reg                  rd_cpbm_q;
   reg [31:0]           rd_hold_q;

   wire [31:0]          mon_count;
   wire [31:0]          mon_capt;
   wire                 mon_ovf;
   wire [15:0]          mem_rdata;

   // RULE17 select by security
   wire [15:0] cur_sel = ns_i ? sel_ns_q : sel_s_q;
   wire [4:0]  mem_idx = {ns_i, cur_sel[`PMCR_PID_W-1:0]};
   wire        sel_ok  = (cur_sel <= `PMCR_PID_MAX);

   function is_off;
      input [15:0] a;
      input [15:0] off;
      begin
         is_off = (a == off);
      end
   endfunction

   wire acc      = req_i && (state_q == ST_IDLE);
   wire wr_acc   = acc && wr_i;
   wire rd_acc   = acc && !wr_i;

   // RULE13 fixed offset decode
   wire hit_idr_lo = is_off(addr_i, `PMCR_OFF_IDR_LO);
   wire hit_idr_hi = is_off(addr_i, `PMCR_OFF_IDR_HI);
   wire hit_monidr = is_off(addr_i, `PMCR_OFF_MON_IDR);
   wire hit_cporid = is_off(addr_i, `PMCR_OFF_CPOR_IDR);
   wire hit_csuid  = is_off(addr_i, `PMCR_OFF_CSUMON_IDR);
   wire hit_ecr    = is_off(addr_i, `PMCR_OFF_ECR);
   wire hit_esr    = is_off(addr_i, `PMCR_OFF_ESR);
   wire hit_sel    = is_off(addr_i, `PMCR_OFF_PART_SEL);
   wire hit_cpbm   = is_off(addr_i, `PMCR_OFF_CPBM);
   wire hit_ctl    = is_off(addr_i, `PMCR_OFF_MON_CTL);
   wire hit_cnt    = is_off(addr_i, `PMCR_OFF_MON_CNT);
   wire hit_capt   = is_off(addr_i, `PMCR_OFF_MON_CAPT);
   wire hit_swc    = is_off(addr_i, `PMCR_OFF_SW_CAPT);
   wire hit_any    = hit_idr_lo | hit_idr_hi | hit_monidr | hit_cporid | hit_csuid |
                     hit_ecr | hit_esr | hit_sel | hit_cpbm | hit_ctl | hit_cnt |
                     hit_capt | hit_swc;

   // ----------------------------------------------------------------------------
   // ID values
   // ----------------------------------------------------------------------------
   reg [63:0]  idr_val;
   reg [31:0]  monidr_val;
   reg [31:0]  cporid_val;
   reg [31:0]  csuid_val;

   // Presence bits sit at header positions so software and logic agree
   always @* begin
      // RULE9 main ID contents
      idr_val                       = 64'h0000000000000000;
      idr_val[15:0]                 = `PMCR_PID_MAX;
      idr_val[23:16]                = `PMCR_PMG_MAX;
      idr_val[`PMCR_IDR_HAS_CPOR]   = 1'b1;
      // RULE11 monitor types present
      idr_val[`PMCR_IDR_HAS_MSMON]  = 1'b1;
      monidr_val                    = 32'h00000000;
      monidr_val[`PMCR_MON_HAS_CSU] = 1'b1;
      // RULE10 class ID register
      cporid_val                    = 32'h00000010;
      // RULE12 monitor type ID
      csuid_val                     = 32'h00000001;
      csuid_val[`PMCR_CSU_HAS_CAPT] = (HAS_CAPTURE != 0);
   end

   // ----------------------------------------------------------------------------
   // Capture selection
   // ----------------------------------------------------------------------------
   wire [2:0] evt_sel = ctl_q[`PMCR_CTL_EVT_HI:`PMCR_CTL_EVT_LO];
   wire [7:0] evt_vec;
   genvar     gi;

   // Unbuilt sources are tied low, so no glitch on their pins can capture
   generate
      for (gi = 0; gi < `PMCR_EVT_SW; gi = gi + 1) begin : g_evt
         assign evt_vec[gi] = EXT_EVT_IMPL[gi] ? ext_capture_i[gi] : 1'b0;
      end
   endgenerate
   assign evt_vec[`PMCR_EVT_SW] = sw_capt_q;
   // RULE3 RULE5 RULE8 pick trigger
   wire       capture = (HAS_CAPTURE != 0) && evt_vec[evt_sel];

   // RULE2 RULE6 masked writable bits
   wire [31:0] ctl_wmask = `PMCR_CTL_WMASK &
      ~({32{HAS_CAPTURE == 0}} & (32'h1 << `PMCR_CTL_EVT_LO) * 32'h7) &
      ~({32{(HAS_CAPTURE == 0) || (MON_RESETABLE == 0)}} & (32'h1 << `PMCR_CTL_RST_CAPT));

   // ----------------------------------------------------------------------------
   // Partition storage
   // ----------------------------------------------------------------------------
   // RULE15 RULE18 write selected partition
   wire mem_we = wr_acc && hit_cpbm && sel_ok;

   pmcr_part_mem i_pmcr_part_mem (
      .clock_i (clock_i),
      .we_i    (mem_we),
      .waddr_i (mem_idx),
      .wdata_i (wdata_i[`PMCR_CPBM_W-1:0]),
      .raddr_i (mem_idx),
      .rdata_o (mem_rdata)
   );

   pmcr_monitor i_pmcr_monitor (
      .clock_i            (clock_i),
      .srst_i             (srst_i),
      .enable_i           (ctl_q[`PMCR_CTL_EN]),
      .count_event_i      (count_event_i),
      .capture_i          (capture),
      .reset_on_capture_i (ctl_q[`PMCR_CTL_RST_CAPT]),
      .overflow_freeze_i  (ctl_q[`PMCR_CTL_OVERFLOW_FREEZE]),
      .cnt_we_i           (wr_acc && hit_cnt),
      .cnt_wdata_i        (wdata_i),
      .stat_clr_i         (wr_acc && hit_ctl && !wdata_i[`PMCR_CTL_OFLOW_STAT]),
      .count_o            (mon_count),
      .capture_o          (mon_capt),
      .overflow_o         (mon_ovf)
   );

   // ----------------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (hit_idr_lo) rd_mux = idr_val[31:0];
      if (hit_idr_hi) rd_mux = idr_val[63:32];
      if (hit_monidr) rd_mux = monidr_val;
      if (hit_cporid) rd_mux = cporid_val;
      if (hit_csuid)  rd_mux = csuid_val;
      if (hit_ecr)    rd_mux = ecr_q;
      if (hit_esr)    rd_mux = esr_q;
      if (hit_sel)    rd_mux = {16'h0000, cur_sel};
      if (hit_ctl)    rd_mux = ctl_q | ({31'h00000000, mon_ovf} << `PMCR_CTL_OFLOW_STAT);
      if (hit_cnt)    rd_mux = mon_count;
      if (hit_capt)   rd_mux = mon_capt;
   end

   // ----------------------------------------------------------------------------
   // Partition select copies
   // ----------------------------------------------------------------------------
   // RULE17 one copy per security
   always @(posedge clock_i) begin
      if (srst_i) begin
         sel_s_q  <= 16'h0000;
         sel_ns_q <= 16'h0000;
      end else if (wr_acc && hit_sel) begin
         if (ns_i) begin
            sel_ns_q <= wdata_i[15:0];
         end else begin
            sel_s_q <= wdata_i[15:0];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Monitor control and software trigger
   // ----------------------------------------------------------------------------
   always @(posedge clock_i) begin
      if (srst_i) begin
         ctl_q          <= 32'h00000000;
         sw_capt_q      <= 1'b0;
         mon_count_en_o <= 1'b0;
      end else begin
         if (wr_acc && hit_ctl) begin
            ctl_q <= wdata_i & ctl_wmask;
         end
         // RULE4 software trigger
         sw_capt_q      <= wr_acc && hit_swc;
         mon_count_en_o <= ctl_q[`PMCR_CTL_EN];
      end
   end

   // ----------------------------------------------------------------------------
   // Error control and status
   // ----------------------------------------------------------------------------
   always @(posedge clock_i) begin
      if (srst_i) begin
         ecr_q <= 32'h00000000;
         esr_q <= 32'h00000000;
      end else if (wr_acc) begin
         if (hit_ecr) begin
            ecr_q <= wdata_i;
         end
         // RULE19 log programming errors
         if (hit_cpbm && !sel_ok) begin
            esr_q <= {4'h0, `PMCR_ERR_PID_RANGE, 8'h00, cur_sel};
         end else if (!hit_any) begin
            esr_q <= {4'h0, `PMCR_ERR_UNMAPPED, 8'h00, addr_i};
         end else if (hit_esr) begin
            esr_q <= wdata_i;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------------------
   // Bitmap reads take one extra cycle because the storage read is registered
   always @(posedge clock_i) begin
      if (srst_i) begin
         state_q   <= ST_IDLE;
         rd_cpbm_q <= 1'b0;
         rd_hold_q <= 32'h00000000;
         rdata_o   <= 32'h00000000;
         ack_o     <= 1'b0;
         cpbm_o    <= 16'h0000;
      end else begin
         ack_o  <= 1'b0;
         cpbm_o <= mem_rdata;
         case (state_q)
            ST_IDLE: begin
               if (wr_acc) begin
                  ack_o <= 1'b1;
               end else if (rd_acc) begin
                  rd_hold_q <= rd_mux;
                  // RULE16 read selected partition
                  if (hit_cpbm) begin
                     state_q   <= ST_READ;
                     rd_cpbm_q <= sel_ok;
                  end else begin
                     ack_o   <= 1'b1;
                     rdata_o <= rd_mux;
                  end
               end
            end
            ST_READ: begin
               ack_o   <= 1'b1;
               rdata_o <= rd_cpbm_q ? {16'h0000, mem_rdata} : rd_hold_q;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // pmcr_regs

//--- bench/pmcr_regs_monitor.sv
// Port-level assertions for the partition and monitor register bank
`include "pmcr_consts.vh"
module pmcr_regs_monitor (
   input wire        clock_i,
   input wire        srst_i,
   input wire        req_i,
   input wire        wr_i,
   input wire        ns_i,
   input wire [15:0] addr_i,
   input wire [31:0] wdata_i,
   input wire [6:0]  ext_capture_i,
   input wire        count_event_i,
   input wire [31:0] rdata_o,
   input wire        ack_o,
   input wire [15:0] cpbm_o,
   input wire        mon_count_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   ack_cause_a: assert property (ack_o |-> $past(req_i) || $past(req_i, 2))
      else $error("ack without a request");
   reset_clear_a: assert property ($fell(srst_i) |->
      !ack_o && rdata_o == 32'h0 && cpbm_o == 16'h0 && !mon_count_en_o)
      else $error("outputs not clear after reset");
   write_ack_a: assert property ($rose(req_i) && wr_i |=> ack_o)
      else $error("write not acknowledged next cycle");
   bitmap_read_a: assert property ($rose(req_i) && !wr_i
      && addr_i == `PMCR_OFF_CPBM |=> !ack_o ##1 ack_o)
      else $error("bitmap read latency wrong");
   plain_read_a: assert property ($rose(req_i) && !wr_i
      && addr_i != `PMCR_OFF_CPBM |=> ack_o)
      else $error("read not acknowledged next cycle");
   unmapped_zero_a: assert property ($rose(req_i) && !wr_i
      && addr_i == 16'h0010 |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   enable_copy_a: assert property ($rose(req_i) && wr_i
      && addr_i == `PMCR_OFF_MON_CTL |-> ##2 mon_count_en_o == $past(wdata_i[31], 2))
      else $error("enable output does not follow control");
   rdata_hold_a: assert property (!ack_o |-> $stable(rdata_o))
      else $error("read data moved without ack");
   cpbm_cause_a: assert property ($changed(cpbm_o)
      |-> $past(req_i) || $past(req_i, 2) || $past(req_i, 3))
      else $error("bitmap output moved without access");

   cover property ($rose(req_i) && !wr_i && addr_i == `PMCR_OFF_CPBM);
   cover property ($rose(req_i) && wr_i && addr_i == `PMCR_OFF_SW_CAPT);
   cover property ($rose(mon_count_en_o));
endmodule // pmcr_regs_monitor

bind pmcr_regs pmcr_regs_monitor i_pmcr_regs_monitor (.clock_i(clock_i), .srst_i(srst_i),
   .req_i(req_i), .wr_i(wr_i), .ns_i(ns_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .ext_capture_i(ext_capture_i), .count_event_i(count_event_i), .rdata_o(rdata_o),
   .ack_o(ack_o), .cpbm_o(cpbm_o), .mon_count_en_o(mon_count_en_o));

//--- bench/pmcr_regs_tb_top.sv
// Self-checking testbench for the partition and monitor register bank
`include "pmcr_consts.vh"
module pmcr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_i;
   logic        srst_i;
   logic        req_i;
   logic        wr_i;
   logic        ns_i;
   logic [15:0] addr_i;
   logic [31:0] wdata_i;
   logic [6:0]  ext_capture_i;
   logic        count_event_i;
   wire  [31:0] rdata_o;
   wire         ack_o;
   wire  [15:0] cpbm_o;
   wire         mon_count_en_o;
   int          fails;
   int          checks;
   logic [31:0] q;

   pmcr_regs i_pmcr_regs (.clock_i(clock_i), .srst_i(srst_i), .req_i(req_i), .wr_i(wr_i),
      .ns_i(ns_i), .addr_i(addr_i), .wdata_i(wdata_i), .ext_capture_i(ext_capture_i),
      .count_event_i(count_event_i), .rdata_o(rdata_o), .ack_o(ack_o), .cpbm_o(cpbm_o),
      .mon_count_en_o(mon_count_en_o));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   // ------------------------------------------------
   // Shared tasks
   // ------------------------------------------------
   task tick;
      begin
         @(posedge clock_i);
         #2;
      end
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         checks++;
         if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
         end
      end
   endtask

   // One-cycle request, then idle until ack; a held request would be taken twice
   task acc(input logic w, input logic n, input logic [15:0] a, input logic [31:0] d);
      int k;
      begin
         k = 0;
         req_i = 1'b1;
         wr_i = w;
         ns_i = n;
         addr_i = a;
         wdata_i = d;
         tick;
         req_i = 1'b0;
         while (ack_o !== 1'b1 && k < 20) begin
            tick;
            k++;
         end
         if (k == 20) fails++;
         q = rdata_o;
         // Idle edge so the next call never re-drives req_i in this time step
         tick;
      end
   endtask

   task ev(input int n);
      repeat (n) begin
         count_event_i = 1'b1;
         tick;
         count_event_i = 1'b0;
         tick;
      end
   endtask

   task ext(input logic [6:0] v);
      begin
         ext_capture_i = v;
         tick;
         ext_capture_i = 7'h00;
         tick;
      end
   endtask

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task t_map;
      begin
         acc(0, 0, 16'h0010, 32'h0); chk(q, 32'h0);
         acc(1, 0, 16'h0010, 32'h0);
         acc(0, 0, `PMCR_OFF_ESR, 32'h0); chk({28'h0, q[27:24]}, 32'h2);
         chk({16'h0, q[15:0]}, 32'h0010);
         acc(0, 0, `PMCR_OFF_IDR_LO, 32'h0); chk({31'h0, q[`PMCR_IDR_HAS_CPOR]}, 32'h1);
         chk({16'h0, q[15:0]}, {16'h0, `PMCR_PID_MAX});
         chk({24'h0, q[23:16]}, {24'h0, `PMCR_PMG_MAX});
         chk({31'h0, q[`PMCR_IDR_HAS_MSMON]}, 32'h1);
         acc(0, 0, `PMCR_OFF_MON_IDR, 32'h0); chk({31'h0, q[`PMCR_MON_HAS_CSU]}, 32'h1);
         acc(0, 0, `PMCR_OFF_CSUMON_IDR, 32'h0); chk({31'h0, q[31]}, 32'h1);
         $display("t_map done");
      end
   endtask

   task t_part;
      begin
         // select first, then configure, per partition
         acc(1, 0, `PMCR_OFF_PART_SEL, 32'h3);
         acc(1, 0, `PMCR_OFF_CPBM, 32'hA5A5);
         acc(1, 0, `PMCR_OFF_PART_SEL, 32'h5);
         acc(1, 0, `PMCR_OFF_CPBM, 32'h1234);
         acc(1, 1, `PMCR_OFF_PART_SEL, 32'h3);
         acc(1, 1, `PMCR_OFF_CPBM, 32'h00FF);
         acc(0, 0, `PMCR_OFF_PART_SEL, 32'h0); chk({16'h0, q[15:0]}, 32'h5);
         acc(0, 0, `PMCR_OFF_CPBM, 32'h0); chk(q, 32'h1234);
         tick;
         tick;
         chk({16'h0, cpbm_o}, 32'h1234);
         acc(1, 0, `PMCR_OFF_PART_SEL, 32'h3);
         acc(0, 0, `PMCR_OFF_CPBM, 32'h0); chk(q, 32'hA5A5);
         acc(0, 1, `PMCR_OFF_CPBM, 32'h0); chk(q, 32'h00FF);
         acc(1, 1, `PMCR_OFF_PART_SEL, 32'h10);
         acc(1, 1, `PMCR_OFF_CPBM, 32'hFFFF);
         acc(0, 1, `PMCR_OFF_CPBM, 32'h0); chk(q, 32'h0);
         acc(1, 1, `PMCR_OFF_PART_SEL, 32'h3);
         acc(0, 1, `PMCR_OFF_CPBM, 32'h0); chk(q, 32'h00FF);
         $display("t_part done");
      end
   endtask

   task t_cap;
      begin
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'hF8000000);
         acc(0, 0, `PMCR_OFF_MON_CTL, 32'h0); chk(q & `PMCR_CTL_WMASK, 32'hF8000000);
         chk({31'h0, mon_count_en_o}, 32'h1);
         acc(1, 0, `PMCR_OFF_MON_CNT, 32'h5);
         ev(3);
         acc(1, 0, `PMCR_OFF_SW_CAPT, 32'h0);
         tick;
         tick;
         acc(0, 0, `PMCR_OFF_MON_CAPT, 32'h0); chk(q, 32'h8);
         acc(0, 0, `PMCR_OFF_MON_CNT, 32'h0); chk(q, 32'h0);
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'hF0000000);
         ev(2);
         acc(1, 0, `PMCR_OFF_SW_CAPT, 32'h0);
         tick;
         tick;
         acc(0, 0, `PMCR_OFF_MON_CAPT, 32'h0); chk(q, 32'h2);
         acc(0, 0, `PMCR_OFF_MON_CNT, 32'h0); chk(q, 32'h2);
         $display("t_cap done");
      end
   endtask

   task t_ext;
      begin
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'h80000000);
         acc(1, 0, `PMCR_OFF_MON_CNT, 32'h9);
         ext(7'h01);
         acc(0, 0, `PMCR_OFF_MON_CAPT, 32'h0); chk(q, 32'h9);
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'h90000000);
         acc(1, 0, `PMCR_OFF_MON_CNT, 32'h4);
         ext(7'h7F);
         acc(0, 0, `PMCR_OFF_MON_CAPT, 32'h0); chk(q, 32'h9);
         $display("t_ext done");
      end
   endtask

   task t_ovf;
      begin
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'h80000000);
         acc(1, 0, `PMCR_OFF_MON_CNT, 32'hFFFFFFFF);
         ev(1);
         acc(0, 0, `PMCR_OFF_MON_CNT, 32'h0); chk(q, 32'h0);
         acc(0, 0, `PMCR_OFF_MON_CTL, 32'h0); chk({31'h0, q[26]}, 32'h1);
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'h81000000);
         acc(0, 0, `PMCR_OFF_MON_CTL, 32'h0); chk({31'h0, q[26]}, 32'h0);
         acc(1, 0, `PMCR_OFF_MON_CNT, 32'hFFFFFFFF);
         ev(1);
         acc(0, 0, `PMCR_OFF_MON_CNT, 32'h0); chk(q, `PMCR_CNT_MAX);
         ev(2);
         acc(0, 0, `PMCR_OFF_MON_CNT, 32'h0); chk(q, `PMCR_CNT_MAX);
         $display("t_ovf done");
      end
   endtask

   task t_off;
      begin
         acc(1, 0, `PMCR_OFF_MON_CTL, 32'h0);
         acc(1, 0, `PMCR_OFF_MON_CNT, 32'h3);
         ev(2);
         acc(0, 0, `PMCR_OFF_MON_CNT, 32'h0); chk(q, 32'h3);
         chk({31'h0, mon_count_en_o}, 32'h0);
         $display("t_off done");
      end
   endtask

   task end_sim;
      begin
         $display("checks %0d fails %0d", checks, fails);
         if (fails == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   // Whole sequence takes well under a thousand cycles
   initial begin
      #100000;
      fails++;
      end_sim;
   end

   initial begin
      fails = 0;
      checks = 0;
      srst_i = 1'b1;
      req_i = 1'b0;
      wr_i = 1'b0;
      ns_i = 1'b0;
      addr_i = 16'h0000;
      wdata_i = 32'h0;
      ext_capture_i = 7'h00;
      count_event_i = 1'b0;
      repeat (12) @(posedge clock_i);
      #2;
      srst_i = 1'b0;
      t_map;
      t_part;
      t_cap;
      t_ext;
      t_ovf;
      t_off;
      end_sim;
   end
endmodule // pmcr_regs_tb_top
